// [design/illumination_driver_control.sv]
`timescale 1ns/1ps


module illumination_driver_control
  import illum_ctrl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic modulation_in,
  output logic illum_drive_main_out,
  output logic illum_drive_main_oe_n_out,
  output logic illum_drive_aux_out,
  output logic illum_drive_aux_oe_n_out,
  output logic preheat_en_out,
  output logic [7:0] sequencer_config_out
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] driver_ctrl_q;
  logic [7:0] sequencer_config_q;
  logic [7:0] status_value;
  logic [7:0] rdata_d;

  // Reserved bits are stored so software reads back what it wrote
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      driver_ctrl_q <= illum_driver_ctrl_reset;
    end else if (clk_en_in && reg_wr_en_in && reg_addr_in == illum_driver_ctrl_addr) begin
      driver_ctrl_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sequencer_config_q <= sequencer_config_reset;
    end else if (clk_en_in && reg_wr_en_in && reg_addr_in == sequencer_config_addr) begin
      sequencer_config_q <= reg_wdata_in;
    end
  end

  assign sequencer_config_out = sequencer_config_q;

  // ----------------------------------------------------------------
  // Preheat
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      preheat_en_out <= illum_driver_ctrl_reset[preheat_bit];
    end else if (clk_en_in) begin
      preheat_en_out <= driver_ctrl_q[preheat_bit];
    end
  end

  // ----------------------------------------------------------------
  // Output stages
  // ----------------------------------------------------------------
  illum_stage_if main_if ();
  illum_stage_if aux_if ();

  assign main_if.enable = driver_ctrl_q[main_select_bit];
  assign main_if.invert = driver_ctrl_q[invert_bit];
  assign main_if.torch = driver_ctrl_q[torch_bit];
  assign main_if.modulation = modulation_in;

  assign aux_if.enable = driver_ctrl_q[aux_select_bit];
  assign aux_if.invert = driver_ctrl_q[invert_bit];
  assign aux_if.torch = driver_ctrl_q[torch_bit];
  assign aux_if.modulation = modulation_in;

  illum_output_stage #(
    .pad_kind(pad_open_drain)
  ) main_stage (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .ctl(main_if.stage),
    .pad_out(illum_drive_main_out),
    .pad_oe_n_out(illum_drive_main_oe_n_out)
  );

  illum_output_stage #(
    .pad_kind(pad_push_pull)
  ) aux_stage (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .ctl(aux_if.stage),
    .pad_out(illum_drive_aux_out),
    .pad_oe_n_out(illum_drive_aux_oe_n_out)
  );

  // ----------------------------------------------------------------
  // Status and read path
  // ----------------------------------------------------------------
  always_comb begin
    status_value = 8'h00;
    status_value[status_main_active_bit] = main_if.level & main_if.enable;
    status_value[status_aux_active_bit] = aux_if.level & aux_if.enable;
    status_value[status_main_oe_n_bit] = illum_drive_main_oe_n_out;
    status_value[status_aux_oe_n_bit] = illum_drive_aux_oe_n_out;
  end

  always_comb begin
    if (reg_addr_in == illum_driver_ctrl_addr) begin
      rdata_d = driver_ctrl_q;
    end else if (reg_addr_in == sequencer_config_addr) begin
      rdata_d = sequencer_config_q;
    end else if (reg_addr_in == illum_status_addr) begin
      rdata_d = status_value;
    end else begin
      rdata_d = unmapped_read_value;
    end
  end

  // Registered read data keeps the output free of decode glitches
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_en_in;
      if (reg_rd_en_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

endmodule // illumination_driver_control

// [design/illum_ctrl_pkg.sv]
package illum_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] illum_driver_ctrl_addr = 8'h90;
  localparam logic [7:0] sequencer_config_addr = 8'h91;
  localparam logic [7:0] illum_status_addr = 8'hfe;

  localparam logic [7:0] illum_driver_ctrl_reset = 8'hc4;
  localparam logic [7:0] sequencer_config_reset = 8'h03;
  localparam logic [7:0] unmapped_read_value = 8'h00;

  // ----------------------------------------------------------------
  // Fields of the driver control register
  // ----------------------------------------------------------------
  localparam int invert_bit = 1;
  localparam int main_select_bit = 2;
  localparam int preheat_bit = 3;
  localparam int torch_bit = 4;
  localparam int aux_select_bit = 5;

  // ----------------------------------------------------------------
  // Fields of the status register
  // ----------------------------------------------------------------
  localparam int status_main_active_bit = 0;
  localparam int status_aux_active_bit = 1;
  localparam int status_main_oe_n_bit = 2;
  localparam int status_aux_oe_n_bit = 3;

  typedef enum logic [1:0] {
    pad_open_drain = 2'b01,
    pad_push_pull = 2'b10
  } pad_kind_type;

endpackage

// [design/illum_stage_if.sv]
`timescale 1ns/1ps

interface illum_stage_if;
  logic enable;
  logic invert;
  logic torch;
  logic modulation;
  logic level;

  modport ctrl (
    output enable,
    output invert,
    output torch,
    output modulation,
    input level
  );

  modport stage (
    input enable,
    input invert,
    input torch,
    input modulation,
    output level
  );
endinterface

// [design/illum_output_stage.sv]
`timescale 1ns/1ps

module illum_output_stage
  import illum_ctrl_pkg::*;
#(
  parameter pad_kind_type pad_kind = pad_push_pull
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  illum_stage_if.stage ctl,
  output logic pad_out,
  output logic pad_oe_n_out
);

  logic level;

  // Torch wins over modulation; polarity applied last
  assign level = (ctl.torch ? 1'b1 : ctl.modulation) ^ ctl.invert;
  assign ctl.level = level;

  // ----------------------------------------------------------------
  // Registered pad drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pad_out <= 1'b0;
      pad_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (!ctl.enable) begin
        // Disabled pad floats; off-chip termination sets its level
        pad_out <= 1'b0;
        pad_oe_n_out <= 1'b1;
      end else if (pad_kind == pad_open_drain) begin
        // Open drain can only pull low: conductive when level is high
        pad_out <= 1'b0;
        pad_oe_n_out <= ~level;
      end else begin
        pad_out <= level;
        pad_oe_n_out <= 1'b0;
      end
    end
  end

endmodule // illum_output_stage

// [sim/illum_emitter_model.sv]
`timescale 1ns/1ps
module illum_emitter_model (
  input wire logic main_in,
  input wire logic main_oe_n_in,
  input wire logic aux_in,
  input wire logic aux_oe_n_in,
  output logic main_lit_out,
  output logic aux_lit_out
);
  // Lit only while the open-drain pad sinks current
  assign main_lit_out = ~main_oe_n_in & ~main_in;
  // Termination holds a floating aux pad at io_ground, so dark
  assign aux_lit_out = ~aux_oe_n_in & aux_in;
endmodule // illum_emitter_model

// [sim/illumination_driver_control_props.sv]
`timescale 1ns/1ps
module illumination_driver_control_props
  import illum_ctrl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic modulation_in,
  input wire logic illum_drive_main_out,
  input wire logic illum_drive_main_oe_n_out,
  input wire logic illum_drive_aux_out,
  input wire logic illum_drive_aux_oe_n_out,
  input wire logic preheat_en_out
);
  logic [7:0] c_q;
  logic lv;
  logic moe;
  logic heat;
  // Shadow of the control register, so pads can be judged without the body
  always_ff @(posedge mclk_in) begin
    if (reset_in) c_q <= illum_driver_ctrl_reset;
    else if (clk_en_in && reg_wr_en_in && reg_addr_in == illum_driver_ctrl_addr)
      c_q <= reg_wdata_in;
  end
  assign lv = (c_q[torch_bit] | modulation_in) ^ c_q[invert_bit];
  assign moe = ~(c_q[main_select_bit] & lv);
  assign heat = c_q[preheat_bit];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  property p_main; clk_en_in |=> illum_drive_main_oe_n_out == $past(moe); endproperty
  property p_main_off;
    clk_en_in && !c_q[main_select_bit] |=> illum_drive_main_oe_n_out && !illum_drive_main_out;
  endproperty
  property p_invert;
    clk_en_in && !modulation_in && !c_q[torch_bit] && c_q[invert_bit] && c_q[main_select_bit]
      |=> !illum_drive_main_oe_n_out;
  endproperty
  property p_aux;
    clk_en_in && c_q[aux_select_bit] |=> !illum_drive_aux_oe_n_out && illum_drive_aux_out == $past(lv);
  endproperty
  property p_aux_off;
    clk_en_in && !c_q[aux_select_bit] |=> illum_drive_aux_oe_n_out && !illum_drive_aux_out;
  endproperty
  property p_torch;
    clk_en_in && c_q[torch_bit] && c_q[aux_select_bit] && !c_q[invert_bit] |=> illum_drive_aux_out;
  endproperty
  property p_preheat; clk_en_in |=> preheat_en_out == $past(heat); endproperty
  a_main: assert property (p_main) else $error("main pad wrong");
  a_main_off: assert property (p_main_off) else $error("main pad not off");
  a_invert: assert property (p_invert) else $error("inverted idle wrong");
  a_aux: assert property (p_aux) else $error("aux pad wrong");
  a_aux_off: assert property (p_aux_off) else $error("aux pad not off");
  a_torch: assert property (p_torch) else $error("torch not on");
  a_preheat: assert property (p_preheat) else $error("preheat wrong");
  c_torch: cover property (p_torch);
  c_invert: cover property (p_invert);
  c_aux_off: cover property (p_aux_off);
endmodule // illumination_driver_control_props
bind illumination_driver_control illumination_driver_control_props props (.*);

// [sim/illumination_driver_control_tb.sv]
`timescale 1ns/1ps
module illumination_driver_control_tb;
  import illum_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, md = 1'b0, ce = 1'b1;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat, seq;
  logic rv, mo, moe, ao, aoe, heat, mlit, alit;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  illumination_driver_control DUT (.mclk_in(clk), .reset_in(rst), .clk_en_in(ce),
    .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(ad), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .modulation_in(md), .illum_drive_main_out(mo),
    .illum_drive_main_oe_n_out(moe), .illum_drive_aux_out(ao), .illum_drive_aux_oe_n_out(aoe),
    .preheat_en_out(heat), .sequencer_config_out(seq));
  illum_emitter_model emitter (.main_in(mo), .main_oe_n_in(moe), .aux_in(ao),
    .aux_oe_n_in(aoe), .main_lit_out(mlit), .aux_lit_out(alit));
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", {7'h00, rv}, 8'h01);
    chk("rdata", rdat, exp);
  endtask
  function automatic logic [7:0] want(logic [7:0] c, logic m);
    logic v;
    v = (c[torch_bit] | m) ^ c[invert_bit];
    return {2'b00, ~(c[main_select_bit] & v), 1'b0, ~c[aux_select_bit], c[aux_select_bit] & v,
      c[main_select_bit] & v, c[aux_select_bit] & v};
  endfunction
  task automatic t_reset;
    rd_chk(illum_driver_ctrl_addr, illum_driver_ctrl_reset);
    rd_chk(sequencer_config_addr, sequencer_config_reset);
    chk("pads", {2'b00, moe, mo, aoe, ao, mlit, alit}, want(illum_driver_ctrl_reset, 1'b0));
    $display("t_reset end");
  endtask
  task automatic t_pads;
    logic [7:0] tbl [6] = '{8'h24, 8'h26, 8'h34, 8'h36, 8'h02, 8'h20};
    foreach (tbl[i]) for (int m = 0; m < 2; m++) begin
      wr_reg(illum_driver_ctrl_addr, tbl[i]);
      md <= m[0];
      repeat (2) @(posedge clk);
      #1;
      chk("pads", {2'b00, moe, mo, aoe, ao, mlit, alit}, want(tbl[i], m[0]));
    end
    $display("t_pads end");
  endtask
  task automatic t_regs;
    wr_reg(illum_driver_ctrl_addr, 8'hc9);
    rd_chk(illum_driver_ctrl_addr, 8'hc9);
    chk("preheat", {7'h00, heat}, 8'h01);
    wr_reg(illum_driver_ctrl_addr, 8'hc0);
    wr_reg(8'h55, 8'hff);
    rd_chk(8'h55, unmapped_read_value);
    chk("preheat", {7'h00, heat}, 8'h00);
    wr_reg(sequencer_config_addr, 8'ha5);
    rd_chk(sequencer_config_addr, 8'ha5);
    chk("seq", seq, 8'ha5);
    @(posedge clk);
    #1;
    chk("rvalid drop", {7'h00, rv}, 8'h00);
    // Status: both pads enabled and active, so both enables low
    wr_reg(illum_driver_ctrl_addr, 8'h24);
    md <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(illum_status_addr, 8'h03);
    wr_reg(illum_status_addr, 8'hff);
    rd_chk(illum_status_addr, 8'h03);
    // Clock enable low must freeze the register against a write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(illum_driver_ctrl_addr, 8'h00);
    ce <= 1'b1;
    rd_chk(illum_driver_ctrl_addr, 8'h24);
    $display("t_regs end");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Run needs under a hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_pads;
    t_regs;
    tally_and_finish;
  end
endmodule // illumination_driver_control_tb
